// file: src/sp_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SP_REGS_VH
`define SP_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SP_OFS_CONTROL 4'h0
`define SP_OFS_BUFFER 4'h1
`define SP_OFS_CONFIG 4'h2
`define SP_OFS_T1_RELOAD 4'h3
`define SP_OFS_T2_CONTROL 4'h4
`define SP_OFS_T2_RELOAD_LOW 4'h5
`define SP_OFS_T2_RELOAD_HIGH 4'h6
`define SP_OFS_NODE_ADDR 4'h7
`define SP_OFS_NODE_MASK 4'h8
`define SP_OFS_STATUS 4'h9

// ----------------------------------------
// serial_control fields
// ----------------------------------------
`define SP_CTL_MODE_HI 7
`define SP_CTL_MODE_LO 6
`define SP_CTL_MPF 5
`define SP_CTL_REN 4
`define SP_CTL_TB8 3
`define SP_CTL_RB8 2
`define SP_CTL_TI 1
`define SP_CTL_RI 0

// ----------------------------------------
// Config, timer 2 control and status fields
// ----------------------------------------
`define SP_CFG_DOUBLER 7
`define SP_CFG_T1_CLK 4
`define SP_CFG_IRQ_EN 0
`define SP_T2_RX_SEL 5
`define SP_T2_TX_SEL 4
`define SP_STS_OVERRUN 0
`define SP_STS_TX_BUSY 1
`define SP_STS_RX_BUSY 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SP_RST_BYTE 8'h00
`define SP_RST_WORD 16'h0000

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SP_M0_DIV 4'hC
`define SP_M0_HALF 4'h6
`define SP_T1_PRESCALE 4'hC
`define SP_OVERSAMPLE 4'hF
`define SP_MID_SAMPLE 4'h7
`define SP_M0_BITS 4'h8
`define SP_FRAME_8BIT 4'hA
`define SP_FRAME_9BIT 4'hB

`endif

// file: src/sp_baud.v
// Baud tick generation: timer 1, timer 2, fixed and mode 0 dividers
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.vh"

module sp_baud (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Configuration
  input wire [1:0] mode,
  input wire baud_doubler,
  input wire timer1_clk_select,
  input wire [7:0] timer1_reload_value,
  input wire [15:0] timer2_reload,
  input wire tx_timer2_select,
  input wire rx_timer2_select,
  // Ticks, one cycle each
  output wire tx_tick,
  output wire rx_tick,
  output wire m0_lo,
  output wire m0_hi
);

  reg [3:0] pre_reg;
  reg [7:0] t1_cnt_reg;
  reg t1_div_reg;
  reg [15:0] t2_cnt_reg;
  reg t2_half_reg;
  reg [1:0] fix_reg;
  wire t1_en;
  wire t1_ovf;
  wire t2_run;
  wire t2_ovf;
  wire t1_tick;
  wire fix_tick;

  // ----------------------------------------
  // Shared divide-by-12 prescaler
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 4'h0;
    end else if (pre_reg == `SP_M0_DIV - 4'h1) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  assign m0_lo = (pre_reg == 4'h0);
  assign m0_hi = (pre_reg == `SP_M0_HALF);

  // ----------------------------------------
  // Timer 1, 8-bit auto reload
  // ----------------------------------------
  // Source is system clock, or system clock / 12
  assign t1_en = timer1_clk_select |
    (pre_reg == `SP_T1_PRESCALE - 4'h1);
  assign t1_ovf = t1_en & (t1_cnt_reg == 8'hFF);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      t1_cnt_reg <= `SP_RST_BYTE;
      t1_div_reg <= 1'b0;
    end else if (t1_en) begin
      if (t1_ovf) begin
        t1_cnt_reg <= timer1_reload_value;
        t1_div_reg <= ~t1_div_reg;
      end else begin
        t1_cnt_reg <= t1_cnt_reg + 8'h01;
      end
    end
  end

  // Without the doubler only every second overflow counts
  assign t1_tick = t1_ovf & (baud_doubler | t1_div_reg);

  // ----------------------------------------
  // Timer 2, 16-bit baud generator at half rate
  // ----------------------------------------
  assign t2_run = tx_timer2_select | rx_timer2_select;
  assign t2_ovf = t2_run & t2_half_reg & (t2_cnt_reg == 16'hFFFF);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      t2_cnt_reg <= `SP_RST_WORD;
      t2_half_reg <= 1'b0;
    end else if (t2_run) begin
      t2_half_reg <= ~t2_half_reg;
      if (t2_ovf) begin
        t2_cnt_reg <= timer2_reload;
      end else if (t2_half_reg) begin
        t2_cnt_reg <= t2_cnt_reg + 16'h0001;
      end
    end else begin
      // Stopped counter tracks the reload so the first bit is full length
      t2_cnt_reg <= timer2_reload;
    end
  end

  // ----------------------------------------
  // Fixed rate for mode 2: clock / 4 or / 2
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fix_reg <= 2'h0;
    end else begin
      fix_reg <= fix_reg + 2'h1;
    end
  end

  assign fix_tick = baud_doubler ? fix_reg[0] : (fix_reg == 2'h3);

  // Each tick is one sixteenth of a bit time
  assign tx_tick = (mode == 2'h2) ? fix_tick :
    (tx_timer2_select ? t2_ovf : t1_tick);
  assign rx_tick = (mode == 2'h2) ? fix_tick :
    (rx_timer2_select ? t2_ovf : t1_tick);

endmodule
`default_nettype wire

// file: src/sp_top.v
// Four-mode serial port: register file, transmitter, receivers
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.vh"

module sp_top (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  // Serial pins
  input wire serial_in_pin_i,
  output reg serial_in_pin_o,
  output reg serial_in_pin_oe,
  output reg serial_out_pin,
  // Interrupt request
  output reg irq
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [1:0] mode_reg;
  reg mpf_reg;
  reg ren_reg;
  reg tb8_reg;
  reg rb8_reg;
  reg ti_reg;
  reg ri_reg;
  reg [7:0] rx_buf_reg;
  reg doubler_reg;
  reg t1_clk_reg;
  reg irq_en_reg;
  reg [7:0] t1_reload_reg;
  reg tx_t2_reg;
  reg rx_t2_reg;
  reg [15:0] t2_reload_reg;
  reg [7:0] node_addr_reg;
  reg [7:0] node_mask_reg;
  reg overrun_reg;
  reg unread_reg;
  // Asynchronous transmitter
  reg tx_busy_reg;
  reg [10:0] tx_shift_reg;
  reg [3:0] tx_bits_reg;
  reg [3:0] tx_sub_reg;
  // Asynchronous receiver
  reg rx_busy_reg;
  reg rx_prev_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_bit_reg;
  reg [9:0] rx_shift_reg;
  // Mode 0 shifter
  reg m0_busy_reg;
  reg m0_rx_reg;
  reg m0_run_reg;
  reg m0_clk_reg;
  reg [3:0] m0_bit_reg;
  reg [7:0] m0_shift_reg;

  wire tx_tick;
  wire rx_tick;
  wire m0_lo;
  wire m0_hi;
  wire wr_ctl;
  wire wr_buf;
  wire rd_buf;
  wire is_m0;
  wire nine_bit;
  wire tx_start;
  wire m0_rx_start;
  wire tx_bit_end;
  wire rx_mid;
  wire rx_last;
  wire [7:0] rx_data;
  wire rx_ninth;
  wire addr_match;
  wire rx_accept;
  wire m0_done;
  wire ti_set;
  wire ri_set;
  wire rx_load;
  wire [7:0] rx_load_data;

  assign wr_ctl = wr_en & (addr == `SP_OFS_CONTROL);
  assign wr_buf = wr_en & (addr == `SP_OFS_BUFFER);
  assign rd_buf = rd_en & (addr == `SP_OFS_BUFFER);
  assign is_m0 = (mode_reg == 2'h0);
  assign nine_bit = mode_reg[1];

  // ----------------------------------------
  // Baud ticks
  // ----------------------------------------
  sp_baud u_baud (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .mode(mode_reg),
    .baud_doubler(doubler_reg),
    .timer1_clk_select(t1_clk_reg),
    .timer1_reload_value(t1_reload_reg),
    .timer2_reload(t2_reload_reg),
    .tx_timer2_select(tx_t2_reg),
    .rx_timer2_select(rx_t2_reg),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick),
    .m0_lo(m0_lo),
    .m0_hi(m0_hi)
  );

  // ----------------------------------------
  // Asynchronous transmitter
  // ----------------------------------------
  // A write while a transfer runs is dropped
  assign tx_start = wr_buf & ~tx_busy_reg & ~m0_busy_reg;
  assign tx_bit_end = tx_busy_reg & tx_tick &
    (tx_sub_reg == `SP_OVERSAMPLE);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 11'h7FF;
      tx_bits_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
    end else if (tx_start & ~is_m0) begin
      tx_busy_reg <= 1'b1;
      tx_sub_reg <= 4'h0;
      if (nine_bit) begin
        tx_shift_reg <= {1'b1, tb8_reg, wr_data, 1'b0};
        tx_bits_reg <= `SP_FRAME_9BIT;
      end else begin
        tx_shift_reg <= {2'h3, wr_data, 1'b0};
        tx_bits_reg <= `SP_FRAME_8BIT;
      end
    end else if (tx_busy_reg & tx_tick) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_bit_end) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
        if (tx_bits_reg == 4'h1) begin
          tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Asynchronous receiver
  // ----------------------------------------
  // Bits are sampled at the eighth tick of sixteen
  assign rx_mid = rx_busy_reg & rx_tick &
    (rx_sub_reg == `SP_MID_SAMPLE);
  assign rx_last = rx_bit_reg ==
    (nine_bit ? `SP_FRAME_9BIT : `SP_FRAME_8BIT) - 4'h1;
  assign rx_data = nine_bit ? rx_shift_reg[8:1] : rx_shift_reg[9:2];
  assign rx_ninth = nine_bit ? rx_shift_reg[9] : serial_in_pin_i;
  assign addr_match =
    ((rx_data ^ node_addr_reg) & node_mask_reg) == 8'h00;
  assign rx_accept = rx_mid & rx_last & ~ri_reg & (~mpf_reg |
    (nine_bit ? (rx_ninth & addr_match) : serial_in_pin_i));

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      rx_sub_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 10'h000;
    end else begin
      rx_prev_reg <= serial_in_pin_i;
      if (~rx_busy_reg) begin
        if (~is_m0 & ren_reg & rx_prev_reg & ~serial_in_pin_i) begin
          rx_busy_reg <= 1'b1;
          rx_sub_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
        end
      end else if (is_m0 | ~ren_reg) begin
        rx_busy_reg <= 1'b0;
      end else if (rx_tick) begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_mid) begin
          rx_bit_reg <= rx_bit_reg + 4'h1;
          rx_shift_reg <= {serial_in_pin_i, rx_shift_reg[9:1]};
          // A start bit that is high again was a glitch
          if ((rx_bit_reg == 4'h0 && serial_in_pin_i) || rx_last) begin
            rx_busy_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Mode 0 synchronous shifter
  // ----------------------------------------
  assign m0_rx_start = is_m0 & ren_reg & ~ri_reg & ~m0_busy_reg &
    ~wr_buf;
  assign m0_done = m0_run_reg & m0_lo & (m0_bit_reg == `SP_M0_BITS);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      m0_busy_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_run_reg <= 1'b0;
      m0_clk_reg <= 1'b1;
      m0_bit_reg <= 4'h0;
      m0_shift_reg <= `SP_RST_BYTE;
    end else if (tx_start & is_m0) begin
      m0_busy_reg <= 1'b1;
      m0_rx_reg <= 1'b0;
      m0_shift_reg <= wr_data;
      m0_bit_reg <= 4'h0;
    end else if (m0_rx_start) begin
      m0_busy_reg <= 1'b1;
      m0_rx_reg <= 1'b1;
      m0_shift_reg <= 8'hFF;
      m0_bit_reg <= 4'h0;
    end else if (m0_busy_reg) begin
      if (m0_lo) begin
        if (m0_done) begin
          m0_busy_reg <= 1'b0;
          m0_run_reg <= 1'b0;
          m0_clk_reg <= 1'b1;
        end else begin
          m0_run_reg <= 1'b1;
          m0_clk_reg <= 1'b0;
          // Send data moves on the falling clock, steady over the rise
          if (m0_run_reg & ~m0_rx_reg) begin
            m0_shift_reg <= {1'b1, m0_shift_reg[7:1]};
          end
        end
      end else if (m0_hi & m0_run_reg) begin
        m0_clk_reg <= 1'b1;
        m0_bit_reg <= m0_bit_reg + 4'h1;
        if (m0_rx_reg) begin
          m0_shift_reg <= {serial_in_pin_i, m0_shift_reg[7:1]};
        end
      end
    end
  end

  // ----------------------------------------
  // Done flags, holding register, overrun
  // ----------------------------------------
  assign ti_set = (tx_bit_end & (tx_bits_reg == 4'h2)) |
    (m0_done & ~m0_rx_reg);
  assign ri_set = rx_accept | (m0_done & m0_rx_reg);
  assign rx_load = ri_set;
  assign rx_load_data = rx_accept ? rx_data : m0_shift_reg;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ti_reg <= 1'b0;
      ri_reg <= 1'b0;
      rb8_reg <= 1'b0;
      rx_buf_reg <= `SP_RST_BYTE;
      unread_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      // Hardware set wins over a software write in the same cycle
      if (ti_set) begin
        ti_reg <= 1'b1;
      end else if (wr_ctl) begin
        ti_reg <= wr_data[`SP_CTL_TI];
      end
      if (ri_set) begin
        ri_reg <= 1'b1;
      end else if (wr_ctl) begin
        ri_reg <= wr_data[`SP_CTL_RI];
      end
      if (rx_accept) begin
        rb8_reg <= rx_ninth;
      end else if (wr_ctl) begin
        rb8_reg <= wr_data[`SP_CTL_RB8];
      end
      if (rx_load) begin
        rx_buf_reg <= rx_load_data;
        unread_reg <= 1'b1;
      end else if (rd_buf) begin
        unread_reg <= 1'b0;
      end
      if (rx_load & unread_reg) begin
        overrun_reg <= 1'b1;
      end else if (wr_en & (addr == `SP_OFS_STATUS) &
          wr_data[`SP_STS_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software-written configuration
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= 2'h0;
      mpf_reg <= 1'b0;
      ren_reg <= 1'b0;
      tb8_reg <= 1'b0;
      doubler_reg <= 1'b0;
      t1_clk_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      t1_reload_reg <= `SP_RST_BYTE;
      tx_t2_reg <= 1'b0;
      rx_t2_reg <= 1'b0;
      t2_reload_reg <= `SP_RST_WORD;
      node_addr_reg <= `SP_RST_BYTE;
      node_mask_reg <= `SP_RST_BYTE;
    end else if (wr_en) begin
      case (addr)
        `SP_OFS_CONTROL: begin
          mode_reg <= wr_data[`SP_CTL_MODE_HI:`SP_CTL_MODE_LO];
          mpf_reg <= wr_data[`SP_CTL_MPF];
          ren_reg <= wr_data[`SP_CTL_REN];
          tb8_reg <= wr_data[`SP_CTL_TB8];
        end
        `SP_OFS_CONFIG: begin
          doubler_reg <= wr_data[`SP_CFG_DOUBLER];
          t1_clk_reg <= wr_data[`SP_CFG_T1_CLK];
          irq_en_reg <= wr_data[`SP_CFG_IRQ_EN];
        end
        `SP_OFS_T1_RELOAD: t1_reload_reg <= wr_data;
        `SP_OFS_T2_CONTROL: begin
          rx_t2_reg <= wr_data[`SP_T2_RX_SEL];
          tx_t2_reg <= wr_data[`SP_T2_TX_SEL];
        end
        `SP_OFS_T2_RELOAD_LOW: t2_reload_reg[7:0] <= wr_data;
        `SP_OFS_T2_RELOAD_HIGH: t2_reload_reg[15:8] <= wr_data;
        `SP_OFS_NODE_ADDR: node_addr_reg <= wr_data;
        `SP_OFS_NODE_MASK: node_mask_reg <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read port, pins and interrupt
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `SP_RST_BYTE;
      serial_in_pin_o <= 1'b0;
      serial_in_pin_oe <= 1'b0;
      serial_out_pin <= 1'b1;
      irq <= 1'b0;
    end else begin
      rd_data <= `SP_RST_BYTE;
      if (rd_en) begin
        case (addr)
          `SP_OFS_CONTROL: rd_data <= {mode_reg, mpf_reg, ren_reg,
            tb8_reg, rb8_reg, ti_reg, ri_reg};
          `SP_OFS_BUFFER: rd_data <= rx_buf_reg;
          `SP_OFS_CONFIG: rd_data <= {doubler_reg, 2'h0, t1_clk_reg,
            3'h0, irq_en_reg};
          `SP_OFS_T1_RELOAD: rd_data <= t1_reload_reg;
          `SP_OFS_T2_CONTROL: rd_data <= {2'h0, rx_t2_reg, tx_t2_reg,
            4'h0};
          `SP_OFS_T2_RELOAD_LOW: rd_data <= t2_reload_reg[7:0];
          `SP_OFS_T2_RELOAD_HIGH: rd_data <= t2_reload_reg[15:8];
          `SP_OFS_NODE_ADDR: rd_data <= node_addr_reg;
          `SP_OFS_NODE_MASK: rd_data <= node_mask_reg;
          `SP_OFS_STATUS: rd_data <= {5'h00, rx_busy_reg | m0_rx_reg &
            m0_busy_reg, tx_busy_reg | ~m0_rx_reg & m0_busy_reg,
            overrun_reg};
          default: rd_data <= `SP_RST_BYTE;
        endcase
      end
      // Data pin only ever pulls low; a pull-up gives the high level
      serial_in_pin_o <= 1'b0;
      serial_in_pin_oe <= is_m0 & m0_busy_reg & m0_run_reg &
        ~m0_rx_reg & ~m0_shift_reg[0];
      serial_out_pin <= is_m0 ? m0_clk_reg : tx_shift_reg[0];
      irq <= irq_en_reg & (ti_reg | ri_reg);
    end
  end

endmodule
`default_nettype wire

// file: verification/sp_top_properties.sv
// Port-level assertions for the serial port top, bound to sp_top
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.vh"

module sp_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  // Pins and request
  input wire logic serial_in_pin_i,
  input wire logic serial_in_pin_o,
  input wire logic serial_in_pin_oe,
  input wire logic serial_out_pin,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Shadows of mode and enable, idle-high run length
  // ----------------------------------------
  logic [1:0] mode_q;
  logic ien_q;
  logic [7:0] quiet;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'h0;
      ien_q <= 1'b0;
      quiet <= 8'h00;
    end else begin
      if (wr_en && addr == `SP_OFS_CONTROL)
        mode_q <= wr_data[`SP_CTL_MODE_HI:`SP_CTL_MODE_LO];
      if (wr_en && addr == `SP_OFS_CONFIG)
        ien_q <= wr_data[`SP_CFG_IRQ_EN];
      if (!serial_out_pin)
        quiet <= 8'h00;
      else if (quiet != 8'hFF)
        quiet <= quiet + 8'h01;
    end
  end
  // Quiet of 8 or more means no mode 0 transfer is clocking the line
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data seen outside its cycle");
  property p_unmapped;
    rd_en && addr > `SP_OFS_STATUS |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_open_drain;
    serial_in_pin_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  property p_clk_low;
    $fell(serial_out_pin) |-> (!serial_out_pin) [*6];
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("low phase shorter than six clocks");
  property p_clk_high;
    $rose(serial_out_pin) |-> serial_out_pin [*6];
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("high phase shorter than six clocks");
  property p_oe_hold;
    $rose(serial_out_pin) |-> $stable(serial_in_pin_oe) [*6];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data moved while shift clock high");
  property p_m0_start;
    wr_en && addr == `SP_OFS_BUFFER && mode_q == 2'h0 && quiet >= 8'h08
      |-> ##[1:14] $fell(serial_out_pin);
  endproperty
  a_m0_start: assert property (p_m0_start)
    else $error("mode 0 write did not start clocking");
  property p_irq_en;
    irq |-> $past(ien_q);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("request raised while disabled");
  property p_irq_off;
    wr_en && addr == `SP_OFS_CONFIG && !wr_data[`SP_CFG_IRQ_EN] |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("request stayed after disable");
  property p_irq_flag;
    wr_en && addr == `SP_OFS_CONTROL && wr_data[`SP_CTL_TI] && ien_q
      |-> ##2 irq;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("flag set without request");
  c_m0: cover property (wr_en && addr == `SP_OFS_BUFFER && mode_q == 2'h0);
  c_irq: cover property ($rose(irq));
  c_rx: cover property (rd_en && addr == `SP_OFS_BUFFER ##1 rd_data != 8'h00);
endmodule

bind sp_top sp_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_o(serial_in_pin_o),
  .serial_in_pin_oe(serial_in_pin_oe), .serial_out_pin(serial_out_pin),
  .irq(irq));
`default_nettype wire

// file: verification/sp_node.sv
// Remote node: async frame sender and monitor, mode 0 shift register
`timescale 1ns/1ps
`default_nettype none

module sp_node (
  // Clock
  input wire logic clk_sys,
  // Lines
  input wire logic serial_out_pin,
  input wire logic data_line,
  output logic drive_level
);
  int bc = 32;
  int nb = 10;
  int cnt = 0;
  logic m0 = 1'b0;
  logic tx_lvl = 1'b1;
  logic m0_seen = 1'b0;
  logic [7:0] m0_out = 8'hFF;
  logic [7:0] m0_in = 8'h00;
  logic [10:0] last = 11'h000;
  // A released line reads high through the pull-up
  assign drive_level = m0 ? m0_out[0] : tx_lvl;
  // Shift register follows the device's clock: take on rise, shift on fall
  always @(posedge serial_out_pin) begin
    if (m0) begin
      m0_in <= {data_line, m0_in[7:1]};
      m0_seen <= 1'b1;
    end
  end
  always @(negedge serial_out_pin) begin
    if (m0 && m0_seen)
      m0_out <= {1'b1, m0_out[7:1]};
  end
  // Monitor samples each bit near its middle, start bit first
  initial begin
    forever begin
      @(negedge serial_out_pin);
      if (!m0) begin
        last = 11'h000;
        repeat (bc / 2) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
          last[i] = serial_out_pin;
          if (i < nb - 1)
            repeat (bc) @(posedge clk_sys);
        end
        cnt++;
      end
    end
  end
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < nb; i++) begin
      tx_lvl <= f[i];
      repeat (bc) @(posedge clk_sys);
    end
    tx_lvl <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verification/test_four_mode_serial_port.sv
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.vh"

module test_four_mode_serial_port;
  logic clk_sys, arst_n, wr_en, rd_en, serial_in_pin_o, serial_in_pin_oe;
  logic serial_out_pin, irq, drive_level, b9, n9, serial_in_pin_i;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, d, g, ctl, last_rx;
  int errors = 0;
  int cmp_count = 0;
  int nb, seed_v;
  logic [7:0] c_ctl [6] = '{8'h50, 8'h90, 8'h90, 8'hD0, 8'h50, 8'h50};
  logic [7:0] c_cfg [6] = '{8'h91, 8'h81, 8'h01, 8'h01, 8'h11, 8'h81};
  logic [7:0] c_t1 [6] = '{8'hFE, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
  logic [7:0] c_t2c [6] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00};
  int c_bc [6] = '{32, 32, 64, 32, 32, 192};
  logic [7:0] a_ctl [6] = '{8'hB0, 8'hB0, 8'hB0, 8'h70, 8'h70, 8'h90};
  logic [7:0] a_d [6] = '{8'h35, 8'hA5, 8'h34, 8'h5A, 8'h5A, 8'hC3};
  logic a_n [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic a_ok [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  // Open-drain data pin: device pulls low, otherwise the node decides
  assign serial_in_pin_i = serial_in_pin_oe ? 1'b0 : drive_level;
  sp_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_o(serial_in_pin_o),
    .serial_in_pin_oe(serial_in_pin_oe), .serial_out_pin(serial_out_pin),
    .irq(irq));
  sp_node p (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin),
    .data_line(serial_in_pin_i), .drive_level(drive_level));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [10:0] mkframe(logic [7:0] v, logic b, int n);
    return (n == 10) ? {2'h0, b, v, 1'b0} | 11'h000 : {1'b1, b, v, 1'b0};
  endfunction
  task automatic chk(input string n, input logic [10:0] e, logic [10:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, string n);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
  endtask
  task automatic wait_frame;
    int n;
    int t;
    n = p.cnt;
    t = 0;
    while (p.cnt == n && t < 4000) begin
      @(posedge clk_sys);
      t++;
    end
  endtask
  task automatic test_done;
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is about 1.35 ms of traffic
  initial begin
    #5000000;
    errors++;
    test_done;
  end
  initial begin
    {arst_n, wr_en, rd_en, addr, wr_data} = '0;
    seed_v = $urandom(57110);
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk(`SP_OFS_CONTROL, 8'h00, "control reset");
    wr(4'hF, 8'h5A);
    rdchk(4'hF, 8'h00, "unmapped");
    chk("line idle", 1'b1, serial_out_pin);
    wr(`SP_OFS_T2_RELOAD_LOW, 8'hFF);
    wr(`SP_OFS_T2_RELOAD_HIGH, 8'hFF);
    // One case per asynchronous mode and baud setting, each bit a known clock count
    for (int k = 0; k < 6; k++) begin
      wr(`SP_OFS_CONFIG, c_cfg[k]);
      wr(`SP_OFS_T1_RELOAD, c_t1[k]);
      wr(`SP_OFS_T2_CONTROL, c_t2c[k]);
      nb = (c_ctl[k][7:6] == 2'h1) ? 10 : 11;
      p.bc = c_bc[k];
      p.nb = nb;
      b9 = 1'($urandom);
      ctl = c_ctl[k] | {4'h0, b9, 3'h0};
      wr(`SP_OFS_CONTROL, ctl);
      // Let the baud timer roll over once so the start bit is full length
      repeat (300) @(posedge clk_sys);
      d = 8'($urandom);
      wr(`SP_OFS_BUFFER, d);
      wait_frame;
      chk("tx frame", mkframe(d, nb == 10 ? 1'b1 : b9, nb), p.last);
      rdchk(`SP_OFS_CONTROL, ctl | 8'h02, "tx done");
      chk("irq", 1'b1, irq);
      wr(`SP_OFS_CONTROL, ctl);
      repeat (c_bc[k]) @(posedge clk_sys);
      d = 8'($urandom);
      n9 = 1'($urandom);
      p.send(mkframe(d, n9, nb));
      repeat (4) @(posedge clk_sys);
      last_rx = d;
      rdchk(`SP_OFS_BUFFER, d, "rx data");
      rdchk(`SP_OFS_CONTROL, ctl | {5'h0, n9, 2'h1}, "rx flags");
      wr(`SP_OFS_CONTROL, c_ctl[k]);
    end
    wr(`SP_OFS_T2_CONTROL, 8'h30);
    wr(`SP_OFS_CONFIG, 8'h81);
    wr(`SP_OFS_NODE_ADDR, 8'h35);
    wr(`SP_OFS_NODE_MASK, 8'h0F);
    p.bc = 32;
    for (int k = 0; k < 6; k++) begin
      rdchk(`SP_OFS_BUFFER, last_rx, "held data");
      wr(`SP_OFS_CONTROL, a_ctl[k]);
      nb = (a_ctl[k][7:6] == 2'h1) ? 10 : 11;
      p.nb = nb;
      p.send(mkframe(a_d[k], a_n[k], nb));
      repeat (4) @(posedge clk_sys);
      if (a_ok[k])
        last_rx = a_d[k];
      g = a_ctl[k] | {5'h0, a_ok[k] & a_n[k], 1'b0, a_ok[k]};
      rdchk(`SP_OFS_CONTROL, g, "accept flags");
    end
    p.nb = 11;
    p.send(mkframe(8'h11, 1'b0, 11));
    wr(`SP_OFS_CONTROL, 8'h90);
    p.send(mkframe(8'h22, 1'b0, 11));
    p.send(mkframe(8'h33, 1'b0, 11));
    repeat (4) @(posedge clk_sys);
    rdchk(`SP_OFS_STATUS, 8'h01, "overrun");
    rdchk(`SP_OFS_BUFFER, 8'h22, "flag blocks load");
    wr(`SP_OFS_CONFIG, 8'h01);
    wr(`SP_OFS_CONTROL, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk("irq set", 1'b1, irq);
    wr(`SP_OFS_CONFIG, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 1'b0, irq);
    wr(`SP_OFS_CONTROL, 8'h00);
    p.m0 = 1'b1;
    p.m0_out = 8'hFF;
    p.m0_seen = 1'b0;
    d = 8'($urandom);
    wr(`SP_OFS_BUFFER, d);
    repeat (120) @(posedge clk_sys);
    chk("mode 0 tx", d, p.m0_in);
    rdchk(`SP_OFS_CONTROL, 8'h02, "mode 0 tx done");
    d = 8'($urandom);
    p.m0_out = d;
    p.m0_seen = 1'b0;
    wr(`SP_OFS_CONTROL, 8'h10);
    repeat (130) @(posedge clk_sys);
    rdchk(`SP_OFS_CONTROL, 8'h11, "mode 0 rx done");
    rdchk(`SP_OFS_BUFFER, d, "mode 0 rx");
    test_done;
  end
endmodule
`default_nettype wire
